/* core/ddp_cfg.svh */
`ifndef DDP_CFG_SVH
`define DDP_CFG_SVH
`define DDP_AUX_ADDR 8'ha2
`define DDP_SEL_BIT 0
`define DDP_ZERO_BIT 2
`define DDP_FLAG_BIT 3
`define DDP_BOOT_BIT 5
`define DDP_PTR_RESET 16'h0000
`define DDP_BOOT_LO 16'hf800
`define DDP_BOOT_HI 16'hffff
`define DDP_AUX_WIDTH 8
`define DDP_AUX_IDLE 8'h00
`define DDP_SEL_RESET 1'b0
`define DDP_FLAG_RESET 1'b0
`define DDP_BOOT_RESET 1'b0
`define DDP_HIT_RESET 1'b0
`define DDP_FUSE_WAIT 1'b1
`endif

/* core/ddp_pkg.sv */
package ddp_pkg;
   typedef enum logic [1:0] {DDP_OP_NONE, DDP_OP_LOAD, DDP_OP_INC} ddp_op_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ddp_sfr_req_t;

   typedef struct packed {
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic sel;
      logic boot_en;
      logic flag;
      logic [7:0] rdata;
      logic [15:0] xaddr;
      logic boot_hit;
      logic fuse_pending;
   } ddp_state_t;
endpackage : ddp_pkg

/* core/ddp_dual_pointer.sv */
`timescale 1ns/10ps
`include "ddp_cfg.svh"
// Functional notes
// - two independent 16-bit data pointers exist and either can form an external data address.
// - bit 0 of the auxiliary register picks pointer zero when clear and pointer one when set.
// - bit 5 enables the boot memory mapping over code addresses f800h to ffffh.
// - bit 3 is a free read/write user flag with no hardware effect.
// - bit 2 reads zero and ignores writes so an increment only toggles the select bit.
// - reserved bits 7, 6, 4 and 1 read indeterminate and software must never set them; this design reads them as zero.
// - the auxiliary register sits at sfr address a2h, whole byte only, no bit addressing.
// - reset clears select and bit 2 and loads the boot enable from the boot jump fuse.
module ddp_dual_pointer (
   input wire logic core_clk, // 50 mhz core clock
   input wire logic sys_rst, // async reset, active high
   input wire ddp_pkg::ddp_sfr_req_t sfr_req, // byte-wide sfr access
   input wire logic sfr_bit_op, // core bit-addressing cycle
   input wire ddp_pkg::ddp_op_t ptr_op, // pointer operation
   input wire logic [15:0] ptr_load_val, // value for pointer load
   input wire logic boot_jump_fuse, // fuse level, sampled after reset
   input wire logic [15:0] code_addr, // current code fetch address
   output logic [7:0] sfr_rdata, // registered read data
   output logic [15:0] xdata_addr, // active pointer for external access
   output logic pointer_select, // current select bit
   output logic boot_map_enable, // boot mapping enable
   output logic boot_space_hit // code fetch falls in mapped boot space
);
   import ddp_pkg::*;

   // the whole register state is one packed struct; one comb block builds its next copy
   ddp_state_t st;
   ddp_state_t next_st;

   // limitation: the core bumps this register by read-modify-write, so the increment
   // trick only toggles the select because bit 2 never holds a one
   // trade-off: reserved bits read zero rather than anything random, which keeps
   // software that masks them honest and costs no storage

   // the register answers only a whole-byte access at its own address
   function automatic logic aux_hit(input ddp_sfr_req_t r, input logic bit_op);
      logic addr_match;
      addr_match = (r.addr == `DDP_AUX_ADDR);
      aux_hit = addr_match && !bit_op;
   endfunction : aux_hit

   // bit-addressed cycles never reach this register, not even a read-modify-write one
   function automatic logic aux_write_hit(input ddp_sfr_req_t r, input logic bit_op);
      aux_write_hit = r.wr && aux_hit(r, bit_op);
   endfunction : aux_write_hit

   // a read has no side effect, so a spurious one is harmless
   function automatic logic aux_read_hit(input ddp_sfr_req_t r, input logic bit_op);
      aux_read_hit = r.rd && aux_hit(r, bit_op);
   endfunction : aux_read_hit

   // only the select, the user flag and the boot enable have storage behind them
   function automatic logic aux_writable(input int idx);
      case (idx)
         `DDP_SEL_BIT: begin
            aux_writable = 1'b1;
         end
         `DDP_FLAG_BIT: begin
            aux_writable = 1'b1;
         end
         `DDP_BOOT_BIT: begin
            aux_writable = 1'b1;
         end
         default: begin
            aux_writable = 1'b0;
         end
      endcase
   endfunction : aux_writable

   // reserved bits read zero so software never sees stray ones there
   function automatic logic [7:0] aux_image(input ddp_state_t s);
      aux_image = `DDP_AUX_IDLE;
      aux_image[`DDP_SEL_BIT] = s.sel;
      aux_image[`DDP_FLAG_BIT] = s.flag;
      aux_image[`DDP_BOOT_BIT] = s.boot_en;
      aux_image[`DDP_ZERO_BIT] = 1'b0;
   endfunction : aux_image

   // a write lands only in the bits with storage; ones in reserved bits and bit 2 are dropped
   function automatic ddp_state_t apply_write(input ddp_state_t s, input logic [7:0] wdata);
      logic [7:0] kept;
      kept = `DDP_AUX_IDLE;
      for (int i = 0; i < `DDP_AUX_WIDTH; i++) begin
         if (aux_writable(i)) begin
            kept[i] = wdata[i];
         end
      end
      apply_write = s;
      apply_write.sel = kept[`DDP_SEL_BIT];
      apply_write.flag = kept[`DDP_FLAG_BIT];
      apply_write.boot_en = kept[`DDP_BOOT_BIT];
   endfunction : apply_write

   // the pointer the core will put on the external address bus
   function automatic logic [15:0] active_ptr(input ddp_state_t s);
      if (s.sel) begin
         active_ptr = s.ptr1;
      end else begin
         active_ptr = s.ptr0;
      end
   endfunction : active_ptr

   // wraps from ffff to 0000; the carry is not kept anywhere
   function automatic logic [15:0] ptr_inc(input logic [15:0] cur);
      ptr_inc = cur + 16'h0001;
   endfunction : ptr_inc

   function automatic logic [15:0] ptr_next(input ddp_op_t op, input logic [15:0] cur,
      input logic [15:0] load_val);
      case (op)
         DDP_OP_LOAD: begin
            ptr_next = load_val;
         end
         DDP_OP_INC: begin
            ptr_next = ptr_inc(cur);
         end
         DDP_OP_NONE: begin
            ptr_next = cur;
         end
         default: begin
            ptr_next = cur;
         end
      endcase
   endfunction : ptr_next

   // only the selected pointer moves; the other keeps its value
   function automatic ddp_state_t step_pointers(input ddp_state_t s, input ddp_op_t op,
      input logic [15:0] load_val);
      step_pointers = s;
      if (s.sel) begin
         step_pointers.ptr1 = ptr_next(op, s.ptr1, load_val);
      end else begin
         step_pointers.ptr0 = ptr_next(op, s.ptr0, load_val);
      end
   endfunction : step_pointers

   // the upper bound is the top of the space, kept so the window reads plainly
   function automatic logic in_boot_space(input logic [15:0] a);
      logic above_lo;
      logic below_hi;
      above_lo = (a >= `DDP_BOOT_LO);
      below_hi = (a <= `DDP_BOOT_HI);
      in_boot_space = above_lo && below_hi;
   endfunction : in_boot_space

   // looks at the fetch address of this cycle, so the flag lags the address by one clock
   function automatic logic boot_hit_of(input logic enable, input logic [15:0] a);
      if (enable) begin
         boot_hit_of = in_boot_space(a);
      end else begin
         boot_hit_of = 1'b0;
      end
   endfunction : boot_hit_of

   always_comb begin
      ddp_state_t stepped;
      // stepped from the current state so a same-cycle select write cannot steer it
      stepped = step_pointers(st, ptr_op, ptr_load_val);
      next_st = st;
      next_st.fuse_pending = 1'b0;

      // the fuse is taken one clock after reset release, once its sense has settled
      if (st.fuse_pending) begin
         next_st.boot_en = boot_jump_fuse;
      end

      // a byte write in the same cycle wins over the fuse
      if (aux_write_hit(sfr_req, sfr_bit_op)) begin
         next_st = apply_write(next_st, sfr_req.wdata);
      end

      // pointer ops follow the select as it stood, so a select write counts from next cycle
      next_st.ptr0 = stepped.ptr0;
      next_st.ptr1 = stepped.ptr1;

      // read data stands for one cycle and is zero otherwise
      if (aux_read_hit(sfr_req, sfr_bit_op)) begin
         next_st.rdata = aux_image(st);
      end else begin
         next_st.rdata = `DDP_AUX_IDLE;
      end

      // copies kept in flops so that every output comes straight from a register
      next_st.xaddr = active_ptr(next_st);
      next_st.boot_hit = boot_hit_of(next_st.boot_en, code_addr);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         // pointers clear too, although the rules leave them open
         st.ptr0 <= `DDP_PTR_RESET;
         st.ptr1 <= `DDP_PTR_RESET;
         st.xaddr <= `DDP_PTR_RESET;
         // select and bit 2 clear; the flag has no reset of its own, zero is chosen
         st.sel <= `DDP_SEL_RESET;
         st.flag <= `DDP_FLAG_RESET;
         // the boot enable waits for the fuse, which is taken after release
         st.boot_en <= `DDP_BOOT_RESET;
         st.fuse_pending <= `DDP_FUSE_WAIT;
         st.boot_hit <= `DDP_HIT_RESET;
         st.rdata <= `DDP_AUX_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // outputs are fields of the state register, no logic in between
   assign sfr_rdata = st.rdata;
   assign xdata_addr = st.xaddr;
   assign pointer_select = st.sel;
   assign boot_map_enable = st.boot_en;
   assign boot_space_hit = st.boot_hit;
endmodule : ddp_dual_pointer

/* testbench/ddp_core_model.sv */
`timescale 1ns/10ps
module ddp_core_model import ddp_pkg::*; (
   input wire logic core_clk, // core clock
   output ddp_sfr_req_t sfr_req, // sfr access
   output ddp_op_t ptr_op, // pointer operation
   output logic [15:0] ptr_load_val // load value
);
   initial begin
      sfr_req = '0;
      ptr_op = DDP_OP_NONE;
      ptr_load_val = '0;
   end
   // one request per call, then a released cycle with the load value inverted
   task cyc(input ddp_sfr_req_t q, input ddp_op_t o, input logic [15:0] v);
      @(negedge core_clk);
      sfr_req <= {q.wr, q.rd, q.addr, q.wdata & 8'h2d};
      ptr_op <= o;
      ptr_load_val <= v;
      @(negedge core_clk);
      sfr_req <= '0;
      ptr_op <= DDP_OP_NONE;
      ptr_load_val <= ~v;
   endtask : cyc
endmodule : ddp_core_model

/* testbench/ddp_dual_pointer_chk.sv */
`timescale 1ns/10ps
module ddp_chk import ddp_pkg::*; (input wire logic core_clk, sys_rst, sfr_bit_op,
   pointer_select, boot_map_enable, boot_space_hit, input wire ddp_sfr_req_t sfr_req,
   input wire ddp_op_t ptr_op, input wire logic [15:0] ptr_load_val, code_addr, xdata_addr,
   input wire logic [7:0] sfr_rdata);
   wire w = sfr_req.wr && sfr_req.addr == 8'ha2 && !sfr_bit_op;
   wire r = sfr_req.rd && sfr_req.addr == 8'ha2 && !sfr_bit_op;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_sel_write: assert property (w |=> pointer_select == $past(sfr_req.wdata[0])) else $error("sel");
   a_boot_write: assert property (w |=> boot_map_enable == $past(sfr_req.wdata[5])) else $error("boot");
   a_boot_hit: assert property (1 |=> boot_space_hit ==
      (boot_map_enable && $past(code_addr) >= 16'hf800)) else $error("hit");
   a_read_image: assert property (r |=> (sfr_rdata & 8'hf7) ==
      {2'b0, $past(boot_map_enable), 4'b0, $past(pointer_select)}) else $error("image");
   a_no_read: assert property (!r |=> sfr_rdata == 8'h00) else $error("rdata");
   a_ctrl_hold: assert property (!w && !$past(sys_rst) |=>
      $stable(pointer_select) && $stable(boot_map_enable)) else $error("hold");
   a_ptr_inc: assert property (ptr_op == DDP_OP_INC && !w |=>
      xdata_addr == $past(xdata_addr) + 16'h1) else $error("inc");
   a_ptr_load: assert property (ptr_op == DDP_OP_LOAD && !w |=>
      xdata_addr == $past(ptr_load_val)) else $error("load");
   a_ptr_idle: assert property (ptr_op == DDP_OP_NONE && !w |=> $stable(xdata_addr)) else $error("idle");
   c_write_read: cover property (w ##2 r);
   c_inc: cover property (ptr_op == DDP_OP_INC);
   c_hit: cover property (boot_space_hit);
endmodule : ddp_chk
bind ddp_dual_pointer ddp_chk i_ddp_chk(.*);

/* testbench/ddp_dual_pointer_tb_top.sv */
`timescale 1ns/10ps
module ddp_dual_pointer_tb_top;
   import ddp_pkg::*;
   typedef struct packed {logic w, r; logic [7:0] a, d; logic [1:0] o;
      logic [15:0] v, x; logic [7:0] q;} ddp_row_t;
   logic core_clk = 0, sys_rst = 1, fuse = 1, sel, bme, bop = 0, hit;
   ddp_sfr_req_t req;
   ddp_op_t op;
   logic [15:0] lv, xa, ca = 16'hf900;
   logic [7:0] rd;
   int bad_count = 0, compares = 0;
   ddp_row_t rows [7] = '{'{0,0,0,0,1,'h1234,'h1234,0}, '{1,0,'ha2,'h21,0,0,0,0},
      '{0,0,0,0,2,0,1,0}, '{0,1,'ha2,0,0,0,1,'h21}, '{1,0,'ha2,'h2c,0,0,'h1234,0},
      '{0,1,'ha2,0,0,0,'h1234,'h28}, '{1,0,'ha3,1,0,0,'h1234,0}};
   always #10 core_clk = ~core_clk;
   ddp_core_model i_ddp_core_model(.core_clk, .sfr_req(req), .ptr_op(op), .ptr_load_val(lv));
   ddp_dual_pointer i_ddp_dual_pointer(.core_clk, .sys_rst, .sfr_req(req), .sfr_bit_op(bop),
      .ptr_op(op), .ptr_load_val(lv), .boot_jump_fuse(fuse), .code_addr(ca),
      .sfr_rdata(rd), .xdata_addr(xa), .pointer_select(sel), .boot_map_enable(bme),
      .boot_space_hit(hit));
   task chk(input string n, input logic [15:0] e, g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task give_verdict;
      if (bad_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (4) @(negedge core_clk);
      sys_rst = 0;
      @(negedge core_clk);
      chk("boot", 1, bme);
      foreach (rows[i]) begin
         i_ddp_core_model.cyc({rows[i].w, rows[i].r, rows[i].a, rows[i].d},
            ddp_op_t'(rows[i].o), rows[i].v);
         chk("xdata", rows[i].x, xa);
         chk("rdata", rows[i].q, rd);
      end
      // wrap of the selected pointer at the top of the space
      i_ddp_core_model.cyc('0, DDP_OP_LOAD, 16'hffff);
      i_ddp_core_model.cyc('0, DDP_OP_INC, 16'h0);
      chk("wrap", 16'h0, xa);
      bop = 1;
      i_ddp_core_model.cyc({1'b1, 1'b0, 8'ha2, 8'h01}, DDP_OP_NONE, 16'h0);
      bop = 0;
      chk("bitop", 0, sel);
      chk("hit", 1, hit);
      ca = 16'hf7ff;
      @(negedge core_clk);
      chk("nohit", 0, hit);
      fuse = 0;
      sys_rst = 1;
      @(negedge core_clk);
      chk("rst", 16'h0, {xa[14:0], sel});
      sys_rst = 0;
      @(negedge core_clk);
      chk("fuse", 0, bme);
      give_verdict;
   end
   initial begin
      #5000;
      bad_count++;
      give_verdict;
   end
endmodule : ddp_dual_pointer_tb_top
